/* usbbd_pkg.sv */
// Purpose: Shared constants, types and carriers of the descriptor DMA
// Assumes: 16-bit system RAM port, byte addressed, little endian
// Notes:   Register offsets are byte addresses on the AHB-Lite port
package usbbd_pkg;

  // AHB-Lite register map
  localparam logic [7:0] REG_CFG  = 8'h00;
  localparam logic [7:0] REG_TBL  = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_LAST = 8'h0c;

  // Configuration register fields and reset values
  localparam int unsigned CFG_MODE_LSB  = 0;
  localparam int unsigned CFG_HOST_BIT  = 2;
  localparam int unsigned CFG_PPRST_BIT = 3;
  localparam logic [1:0]  CFG_MODE_RST  = 2'h0;
  localparam logic        CFG_HOST_RST  = 1'b0;
  localparam logic [7:0]  TBL_RST       = 8'h00;

  // Block status register fields
  localparam int unsigned ST_BUSY_BIT  = 0;
  localparam int unsigned ST_NOOWN_BIT = 1;
  localparam int unsigned ST_SLOT_LSB  = 8;

  // Descriptor status word, module-written view
  localparam int unsigned BD_OWN_BIT = 15;
  localparam int unsigned BD_TOG_BIT = 14;
  localparam int unsigned BD_PID_LSB = 10;
  localparam int unsigned BD_BC_LSB  = 0;
  localparam int unsigned BD_BC_W    = 10;

  // Descriptor words inside one slot
  localparam logic BD_WORD_STAT = 1'b0;
  localparam logic BD_WORD_ADDR = 1'b1;

  typedef enum logic [1:0] {
    MODE_NOPP      = 2'h0,
    MODE_PP_EP0OUT = 2'h1,
    MODE_PP_ALL    = 2'h2,
    MODE_PP_NOT0   = 2'h3
  } usbbd_mode_e;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_PPW  = 6'h02,
    ST_STAT = 6'h04,
    ST_ADR  = 6'h08,
    ST_XFER = 6'h10,
    ST_WB   = 6'h20
  } usbbd_state_e;

  typedef struct packed {
    logic [3:0] ep;
    logic       in_dir;
    logic [3:0] tok_pid;
  } usbbd_req_s;

  typedef struct packed {
    logic       data1;
    logic [3:0] pid;
  } usbbd_done_s;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [1:0]  be;
  } usbbd_mem_s;

endpackage : usbbd_pkg

/* usbbd_ppbank.sv */
// Purpose: Even/odd pointer bank, one bit per endpoint direction
// Assumes: Index is {endpoint, direction}
// Notes:   Read data is registered, one cycle after the index
`timescale 1ns/10ps
module usbbd_ppbank #(
  parameter int unsigned N  = 32,
  parameter int unsigned IW = 5
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          clr,
  input  wire logic          tgl,
  input  wire logic [IW-1:0] tgl_idx,
  input  wire logic [IW-1:0] rd_idx,
  output logic               rd_bit
);
  logic [N-1:0] odd_r;

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_ent
      // Toggle beats a software reset in the same cycle so no completion is lost
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          odd_r[gi] <= 1'b0;
        end else if (tgl && (tgl_idx == IW'(gi))) begin
          odd_r[gi] <= ~odd_r[gi];
        end else if (clr) begin
          odd_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_bit <= 1'b0;
    end else begin
      rd_bit <= odd_r[rd_idx];
    end
  end
endmodule : usbbd_ppbank

/* usbbd_dma.sv */
// Purpose: Descriptor table DMA of a USB controller
// Assumes: One clock; SIE and RAM port are on hclk
// Notes:   Zero-wait AHB-Lite slave for configuration
// Contract
// - All descriptor and buffer traffic uses this port
// - Mode 0 uses slots 2n and 2n+1
// - Mode 1 ping-pongs EP0 OUT only
// - Mode 2 ping-pongs every endpoint direction
// - Mode 3 ping-pongs all except EP0
// - Ping-pong directions alternate even and odd
// - Status bit 14 gives the data toggle
// - Completion writes PID into bits 13..10
// - Device mode stores received token PID
// - Host mode stores returned PID or status
// - Owned bit set means module owns descriptor
// - Byte count field gets actual bytes moved
// - Two words per slot, from base and slot
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
module usbbd_dma
  import usbbd_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              sie_req_valid,
  input  wire usbbd_pkg::usbbd_req_s  sie_req,
  output logic                   sie_grant,
  output logic                   sie_noown,
  output logic                   sie_bd_data1,
  output logic [9:0]             sie_bd_count,
  input  wire logic              sie_dat_req,
  input  wire logic              sie_dat_wr,
  input  wire logic [7:0]        sie_dat_wdata,
  output logic                   sie_dat_ack,
  output logic [7:0]             sie_dat_rdata,
  input  wire logic              sie_done_valid,
  input  wire usbbd_pkg::usbbd_done_s sie_done,
  output logic                   sie_cmpl,
  output logic                   sie_busy,
  output logic                   mem_valid,
  output usbbd_pkg::usbbd_mem_s  mem_cmd,
  input  wire logic              mem_ack,
  input  wire logic [15:0]       mem_rdata
);
  import usbbd_pkg::*;

  usbbd_state_e state_r;
  usbbd_mode_e  mode_r;
  logic         host_r;
  logic [7:0]   tbl_r;
  logic         pprst_r;
  logic         wr_pend_r;
  logic [7:0]   wr_addr_r;
  usbbd_req_s   req_r;
  logic [5:0]   slot_r;
  logic [15:0]  buf_r;
  logic [9:0]   cnt_r;
  logic         done_pend_r;
  logic [15:0]  wb_r;
  logic [15:0]  last_wb_r;
  logic [5:0]   last_slot_r;
  logic         last_noown_r;
  logic         pp_bit;
  logic [4:0]   pp_rd_idx;
  logic         pp_tgl;
  logic         ahb_sel;
  logic [15:0]  dat_addr;
  logic         dat_issue;
  logic         mem_idle;

  // Mode to slot mapping for one endpoint direction
  function automatic logic [5:0] usbbd_slot(input usbbd_mode_e m, input logic [3:0] ep,
                                            input logic d, input logic pp);
    logic [5:0] s;
    s = 6'h00;
    case (m)
      MODE_NOPP: begin
        s = {1'b0, ep, d};
      end
      MODE_PP_EP0OUT: begin
        if (ep == 4'h0) begin
          s = d ? 6'h02 : {5'h00, pp};
        end else begin
          s = {1'b0, ep, d} + 6'h01;
        end
      end
      MODE_PP_ALL: begin
        s = {ep, d, pp};
      end
      MODE_PP_NOT0: begin
        if (ep == 4'h0) begin
          s = {5'h00, d};
        end else begin
          s = {ep, d, pp} - 6'h02;
        end
      end
      default: begin
        s = 6'h00;
      end
    endcase
    return s;
  endfunction : usbbd_slot

  // Whether a direction keeps an even and an odd descriptor
  function automatic logic usbbd_is_pp(input usbbd_mode_e m, input logic [3:0] ep,
                                       input logic d);
    logic p;
    p = 1'b0;
    case (m)
      MODE_NOPP:      p = 1'b0;
      MODE_PP_EP0OUT: p = (ep == 4'h0) && !d;
      MODE_PP_ALL:    p = 1'b1;
      MODE_PP_NOT0:   p = (ep != 4'h0);
      default:        p = 1'b0;
    endcase
    return p;
  endfunction : usbbd_is_pp

  // Descriptor word address; address bit 8 stays zero as the table is 512-byte aligned
  function automatic logic [15:0] usbbd_bd_addr(input logic [7:0] tp, input logic [5:0] sl,
                                                input logic w);
    return {tp[7:1], 1'b0, sl, w, 1'b0};
  endfunction : usbbd_bd_addr

  // ---------------- AHB-Lite slave ----------------
  assign ahb_sel = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata    <= 32'h0000_0000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_r <= ahb_sel && hwrite;
      if (ahb_sel) begin
        wr_addr_r <= haddr[7:0];
      end
      if (ahb_sel && !hwrite) begin
        case (haddr[7:0])
          REG_CFG:  hrdata <= {29'h0, host_r, mode_r};
          REG_TBL:  hrdata <= {24'h0, tbl_r};
          REG_STAT: hrdata <= {18'h0, last_slot_r, 6'h00, last_noown_r,
                               (state_r != ST_IDLE)};
          REG_LAST: hrdata <= {16'h0, last_wb_r};
          default:  hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Mode change while a transfer runs moves the slot from the next request on, but the pointer toggle at writeback already uses the new mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r  <= usbbd_mode_e'(CFG_MODE_RST);
      host_r  <= CFG_HOST_RST;
      tbl_r   <= TBL_RST;
      pprst_r <= 1'b0;
    end else begin
      pprst_r <= 1'b0;
      if (wr_pend_r && (wr_addr_r == REG_CFG)) begin
        mode_r  <= usbbd_mode_e'(hwdata[CFG_MODE_LSB +: 2]);
        host_r  <= hwdata[CFG_HOST_BIT];
        pprst_r <= hwdata[CFG_PPRST_BIT];
      end
      if (wr_pend_r && (wr_addr_r == REG_TBL)) begin
        tbl_r <= hwdata[7:0];
      end
    end
  end

  // ---------------- Ping-pong pointers ----------------
  assign pp_rd_idx = (state_r == ST_IDLE) ? {sie_req.ep, sie_req.in_dir}
                                          : {req_r.ep, req_r.in_dir};
  assign pp_tgl    = (state_r == ST_WB) && mem_valid && mem_ack &&
                     usbbd_is_pp(mode_r, req_r.ep, req_r.in_dir);

  usbbd_ppbank #(
    .N  (32),
    .IW (5)
  ) u_pp (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clr     (pprst_r),
    .tgl     (pp_tgl),
    .tgl_idx ({req_r.ep, req_r.in_dir}),
    .rd_idx  (pp_rd_idx),
    .rd_bit  (pp_bit)
  );

  // ---------------- Descriptor sequencer ----------------
  assign mem_idle  = !mem_valid;
  assign dat_addr  = buf_r + {6'h00, cnt_r};
  assign dat_issue = (state_r == ST_XFER) && mem_idle && sie_dat_req && !done_pend_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r      <= ST_IDLE;
      req_r        <= '0;
      slot_r       <= 6'h00;
      buf_r        <= 16'h0000;
      cnt_r        <= 10'h000;
      done_pend_r  <= 1'b0;
      wb_r         <= 16'h0000;
      last_wb_r    <= 16'h0000;
      last_slot_r  <= 6'h00;
      last_noown_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (sie_req_valid) begin
            req_r   <= sie_req;
            state_r <= ST_PPW;
          end
        end
        ST_PPW: begin
          slot_r  <= usbbd_slot(mode_r, req_r.ep, req_r.in_dir, pp_bit);
          state_r <= ST_STAT;
        end
        ST_STAT: begin
          if (mem_valid && mem_ack) begin
            last_slot_r <= slot_r;
            if (mem_rdata[BD_OWN_BIT]) begin
              last_noown_r <= 1'b0;
              cnt_r        <= 10'h000;
              done_pend_r  <= 1'b0;
              state_r      <= ST_ADR;
            end else begin
              last_noown_r <= 1'b1;
              state_r      <= ST_IDLE;
            end
          end
        end
        ST_ADR: begin
          if (mem_valid && mem_ack) begin
            buf_r   <= mem_rdata;
            state_r <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (mem_valid && mem_ack) begin
            cnt_r <= cnt_r + 10'h001;
          end
          if (sie_done_valid) begin
            done_pend_r <= 1'b1;
            wb_r        <= {1'b0, sie_done.data1,
                            host_r ? sie_done.pid : req_r.tok_pid,
                            10'h000};
          end
          if (done_pend_r && mem_idle) begin
            wb_r[BD_BC_LSB +: BD_BC_W] <= cnt_r;
            state_r                    <= ST_WB;
          end
        end
        ST_WB: begin
          if (mem_valid && mem_ack) begin
            last_wb_r <= wb_r;
            state_r   <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------- RAM port ----------------
  // Every descriptor and buffer access goes out here, never through the CPU
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_valid <= 1'b0;
      mem_cmd   <= '0;
    end else begin
      if (mem_valid && mem_ack) begin
        mem_valid <= 1'b0;
      end else if (mem_idle) begin
        if ((state_r == ST_STAT) || (state_r == ST_ADR)) begin
          mem_valid     <= 1'b1;
          mem_cmd.we    <= 1'b0;
          mem_cmd.be    <= 2'h3;
          mem_cmd.wdata <= 16'h0000;
          mem_cmd.addr  <= usbbd_bd_addr(tbl_r, slot_r,
                             (state_r == ST_ADR) ? BD_WORD_ADDR : BD_WORD_STAT);
        end else if (dat_issue) begin
          mem_valid     <= 1'b1;
          mem_cmd.we    <= sie_dat_wr;
          mem_cmd.be    <= dat_addr[0] ? 2'h2 : 2'h1;
          mem_cmd.wdata <= {sie_dat_wdata, sie_dat_wdata};
          mem_cmd.addr  <= dat_addr;
        end else if ((state_r == ST_XFER) && done_pend_r) begin
          mem_valid     <= 1'b1;
          mem_cmd.we    <= 1'b1;
          mem_cmd.be    <= 2'h3;
          mem_cmd.wdata <= {wb_r[15:BD_BC_W], cnt_r};
          mem_cmd.addr  <= usbbd_bd_addr(tbl_r, slot_r, BD_WORD_STAT);
        end
      end
    end
  end

  // ---------------- SIE answers ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sie_grant     <= 1'b0;
      sie_noown     <= 1'b0;
      sie_bd_data1  <= 1'b0;
      sie_bd_count  <= 10'h000;
      sie_dat_ack   <= 1'b0;
      sie_dat_rdata <= 8'h00;
      sie_cmpl      <= 1'b0;
      sie_busy      <= 1'b0;
    end else begin
      sie_grant   <= (state_r == ST_ADR) && mem_valid && mem_ack;
      sie_noown   <= (state_r == ST_STAT) && mem_valid && mem_ack &&
                     !mem_rdata[BD_OWN_BIT];
      sie_dat_ack <= (state_r == ST_XFER) && mem_valid && mem_ack;
      sie_cmpl    <= (state_r == ST_WB) && mem_valid && mem_ack;
      sie_busy    <= (state_r != ST_IDLE) || sie_req_valid;
      if ((state_r == ST_STAT) && mem_valid && mem_ack) begin
        // Software view: toggle and byte limit for the SIE to honour
        sie_bd_data1 <= mem_rdata[BD_TOG_BIT];
        sie_bd_count <= mem_rdata[BD_BC_LSB +: BD_BC_W];
      end
      if ((state_r == ST_XFER) && mem_valid && mem_ack) begin
        sie_dat_rdata <= mem_cmd.addr[0] ? mem_rdata[15:8] : mem_rdata[7:0];
      end
    end
  end

endmodule : usbbd_dma

/* usbbd_ram_model.sv */
// Purpose: Behavioural system RAM on the descriptor DMA port
// Assumes: 2 KiB covers table and buffers; little endian byte lanes
// Notes:   Latency alternates fast and slow; idle read data is scrambled
`timescale 1ns/10ps
module usbbd_ram_model
  import usbbd_pkg::*;
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  mem_valid,
  input  wire usbbd_pkg::usbbd_mem_s mem_cmd,
  output logic                       mem_ack,
  output logic [15:0]                mem_rdata
);
  logic [15:0] mem [0:1023];
  logic [1:0]  wait_r;
  logic        slow_r;
  // One flat array, so table and buffers share a contiguous space
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_ack   <= 1'b0;
      wait_r    <= 2'h0;
      slow_r    <= 1'b0;
      mem_rdata <= 16'h5a5a;
    end else if (mem_valid && !mem_ack && wait_r == {slow_r, 1'b0}) begin
      mem_ack   <= 1'b1;
      wait_r    <= 2'h0;
      slow_r    <= ~slow_r;
      mem_rdata <= mem[mem_cmd.addr[10:1]];
      if (mem_cmd.we && mem_cmd.be[0]) mem[mem_cmd.addr[10:1]][7:0] <= mem_cmd.wdata[7:0];
      if (mem_cmd.we && mem_cmd.be[1]) mem[mem_cmd.addr[10:1]][15:8] <= mem_cmd.wdata[15:8];
    end else begin
      mem_ack   <= 1'b0;
      wait_r    <= (mem_valid && !mem_ack) ? wait_r + 2'h1 : 2'h0;
      // Stale data must not look valid outside an acknowledge
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : usbbd_ram_model

/* usbbd_dma_assertions.sv */
// Purpose: Port-level checks of the descriptor DMA
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Relations only between top-level port signals
`timescale 1ns/10ps
module usbbd_dma_chk
  import usbbd_pkg::*;
(
  input wire logic                  hclk,
  input wire logic                  hresetn,
  input wire logic                  hresp,
  input wire logic                  sie_req_valid,
  input wire logic                  sie_grant,
  input wire logic                  sie_noown,
  input wire logic                  sie_dat_ack,
  input wire logic                  sie_cmpl,
  input wire logic                  sie_busy,
  input wire logic                  mem_valid,
  input wire usbbd_pkg::usbbd_mem_s mem_cmd,
  input wire logic                  mem_ack,
  input wire logic [15:0]           mem_rdata
);
  default clocking dcb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("bus response not OKAY");
  busy_after_req_a: assert property (sie_req_valid && !sie_busy |=> sie_busy)
    else $error("request not taken");
  mem_hold_a: assert property (mem_valid && !mem_ack |=> mem_valid && $stable(mem_cmd))
    else $error("RAM request dropped or changed");
  noown_unowned_a: assert property (sie_noown |-> $past(mem_ack) && !$past(mem_rdata[15]))
    else $error("refusal without clear owner bit");
  grant_addr_a: assert property (sie_grant |-> $past(mem_ack) && $past(mem_cmd.addr[1]))
    else $error("grant not after address word");
  byte_ack_a: assert property (sie_dat_ack |-> $past(mem_ack))
    else $error("byte ack without RAM ack");
  cmpl_after_wb_a: assert property (sie_cmpl |-> $past(mem_ack) && $past(mem_cmd.we))
    else $error("completion without writeback");
  wb_clear_own_a: assert property (mem_valid && mem_cmd.we && mem_cmd.be == 2'h3 |-> !mem_cmd.wdata[15])
    else $error("writeback keeps owner bit");
endmodule : usbbd_dma_chk

bind usbbd_dma usbbd_dma_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hresp(hresp),
  .sie_req_valid(sie_req_valid), .sie_grant(sie_grant), .sie_noown(sie_noown),
  .sie_dat_ack(sie_dat_ack), .sie_cmpl(sie_cmpl), .sie_busy(sie_busy), .mem_valid(mem_valid),
  .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

/* usbbd_dma_bench.sv */
// Purpose: Self-checking bench of the descriptor DMA
// Assumes: Table at byte 0x200, one buffer at byte 0x40
// Notes:   Slots are predicted from endpoint, direction, mode and pointer
`timescale 1ns/10ps
module usbbd_dma_bench;
  import usbbd_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic        hreadyout, hresp, sie_grant, sie_noown, sie_bd_data1, sie_dat_ack;
  logic        sie_req_valid = 1'b0, sie_dat_req = 1'b0, sie_dat_wr = 1'b0;
  logic        sie_done_valid = 1'b0, sie_cmpl, sie_busy, mem_valid, mem_ack;
  logic [9:0]  sie_bd_count;
  logic [7:0]  sie_dat_wdata = 8'h0, sie_dat_rdata;
  logic [15:0] mem_rdata;
  usbbd_req_s  sie_req = '0;
  usbbd_done_s sie_done = '0;
  usbbd_mem_s  mem_cmd;
  int          num_errors = 0, check_count = 0, cycles = 0, mode = 0;
  logic        host = 1'b0, tog = 1'b0;
  logic        pp [32];
  int          eps [4] = '{0, 0, 1, 15};
  int          dirs [4] = '{0, 1, 1, 0};
  usbbd_dma uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .sie_req_valid(sie_req_valid), .sie_req(sie_req),
    .sie_grant(sie_grant), .sie_noown(sie_noown), .sie_bd_data1(sie_bd_data1),
    .sie_bd_count(sie_bd_count), .sie_dat_req(sie_dat_req), .sie_dat_wr(sie_dat_wr),
    .sie_dat_wdata(sie_dat_wdata), .sie_dat_ack(sie_dat_ack), .sie_dat_rdata(sie_dat_rdata),
    .sie_done_valid(sie_done_valid), .sie_done(sie_done), .sie_cmpl(sie_cmpl),
    .sie_busy(sie_busy), .mem_valid(mem_valid), .mem_cmd(mem_cmd), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  usbbd_ram_model ram (.hclk(hclk), .hresetn(hresetn), .mem_valid(mem_valid),
    .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  initial begin
    forever #4 hclk = ~hclk;
  end
  task automatic stop_test();
    $display("errors %0d, checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // A hang anywhere ends the run as a mismatch
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic ahb(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb
  task automatic rd_chk(input logic [31:0] a, exp);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd_chk
  task automatic set_cfg(input int m, input logic h);
    logic [31:0] q;
    mode = m;
    host = h;
    ahb(1'b1, 32'(REG_CFG), 32'(m) | (32'(h) << 2) | 32'h8, q);
    for (int i = 0; i < 32; i++) pp[i] = 1'b0;
  endtask : set_cfg
  function automatic int slot(int m, int e, int d, logic o);
    case (m)
      0: return 2 * e + d;
      1: return (e == 0 && d == 0) ? int'(o) : 2 * e + 1 + d;
      2: return 4 * e + 2 * d + int'(o);
      default: return (e == 0) ? d : 4 * e - 2 + 2 * d + int'(o);
    endcase
  endfunction : slot
  function automatic logic seen(input int w);
    case (w)
      0: return sie_grant | sie_noown;
      1: return sie_dat_ack;
      default: return sie_cmpl;
    endcase
  endfunction : seen
  task automatic await(input int w);
    int k;
    for (k = 0; k < 64 && seen(w) !== 1'b1; k++) @(posedge hclk);
    if (k == 64) chk(32'h0, 32'h1);
  endtask : await
  task automatic sie_pulse(input int w);
    @(posedge hclk);
    if (w == 0) sie_req_valid <= 1'b1;
    else if (w == 1) sie_dat_req <= 1'b1;
    else sie_done_valid <= 1'b1;
    @(posedge hclk);
    sie_req_valid <= 1'b0;
    sie_dat_req <= 1'b0;
    sie_done_valid <= 1'b0;
    await(w);
  endtask : sie_pulse
  task automatic run(input int ep, dir, n, input logic own);
    int s, w;
    logic [3:0] pid;
    logic [15:0] st;
    s = slot(mode, ep, dir, pp[2 * ep + dir]);
    w = 16'h100 + 2 * s;
    pid = dir ? 4'h9 : 4'h1;
    tog = ~tog;
    st = {own, tog, 4'h0, 10'(n)};
    ram.mem[w] = st;
    ram.mem[w + 1] = 16'h0040;
    for (int i = 0; i < 4; i++) ram.mem[32 + i / 2][8 * (i % 2) +: 8] = 8'ha0 + 8'(i);
    sie_req <= '{4'(ep), dir[0], pid};
    sie_pulse(0);
    if (!own) begin
      chk(32'({sie_noown, ram.mem[w]}), {15'h0, 1'b1, st});
      rd_chk(32'(REG_STAT), (32'(s) << 8) | 32'h2);
      return;
    end
    chk(32'({sie_grant, sie_bd_data1, sie_bd_count}), {20'h0, 1'b1, tog, 10'(n)});
    for (int i = 0; i < n; i++) begin
      sie_dat_wr <= ~dir[0];
      sie_dat_wdata <= 8'hc0 + 8'(i);
      sie_pulse(1);
      if (dir != 0) chk(32'(sie_dat_rdata), 32'(8'ha0 + 8'(i)));
      else chk(32'(ram.mem[32 + i / 2][8 * (i % 2) +: 8]), 32'(8'hc0 + 8'(i)));
    end
    sie_done <= '{~tog, 4'h2};
    sie_pulse(2);
    st = {1'b0, ~tog, host ? 4'h2 : pid, 10'(n)};
    chk(32'(ram.mem[w]), 32'(st));
    rd_chk(32'(REG_LAST), 32'(st));
    rd_chk(32'(REG_STAT), 32'(s) << 8);
    pp[2 * ep + dir] = ~pp[2 * ep + dir];
  endtask : run
  initial begin
    logic [31:0] q;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(32'(REG_CFG), 32'h0);
    rd_chk(32'(REG_TBL), 32'h0);
    rd_chk(32'(REG_STAT), 32'h0);
    rd_chk(32'h10, 32'h0);
    ahb(1'b1, 32'(REG_TBL), 32'h2, q);
    rd_chk(32'(REG_TBL), 32'h2);
    for (int m = 0; m < 4; m++) begin
      set_cfg(m, 1'b0);
      rd_chk(32'(REG_CFG), 32'(m));
      foreach (eps[i]) repeat (2) run(eps[i], dirs[i], i + 1, 1'b1);
    end
    run(3, 0, 2, 1'b0);
    set_cfg(2, 1'b0);
    run(1, 1, 1, 1'b1);
    set_cfg(2, 1'b0);
    run(1, 1, 3, 1'b1);
    set_cfg(0, 1'b1);
    run(0, 0, 2, 1'b1);
    run(0, 1, 4, 1'b1);
    stop_test();
  end
endmodule : usbbd_dma_bench
